// ---- hw/rmch_defs.vh ----
`ifndef RMCH_DEFS_VH
`define RMCH_DEFS_VH

// serial command codes
`define RMCH_CMD_SET_IV     8'h11
`define RMCH_CMD_SET_KEY    8'h12
`define RMCH_CMD_READ_IV    8'h13
`define RMCH_CMD_READ_KEY   8'h14

// argument sizes in bytes
`define RMCH_ARG_BYTES      5'h10
`define RMCH_BLOCK_BYTES    6'h10

// reply packet type bytes
`define RMCH_RSP_ACK        8'h01
`define RMCH_RSP_NACK       8'h02
`define RMCH_RSP_ASYNC      8'h03

// tag operation codes
`define RMCH_OP_NONE        8'h00
`define RMCH_OP_GET_UID     8'h01
`define RMCH_OP_READ_BLK    8'h02
`define RMCH_OP_WRITE_BLK   8'h03
`define RMCH_OP_READ_DBLK   8'h04
`define RMCH_OP_WRITE_DBLK  8'h05
`define RMCH_OP_READ_PAGE   8'h06
`define RMCH_OP_WRITE_PAGE  8'h07
`define RMCH_OP_ENCRYPT     8'h08
`define RMCH_OP_DECRYPT     8'h09
`define RMCH_OP_READ_VAL    8'h0A
`define RMCH_OP_WRITE_VAL   8'h0B
`define RMCH_OP_INC_VAL     8'h0C
`define RMCH_OP_DEC_VAL     8'h0D
`define RMCH_OP_RESTORE     8'h0E
`define RMCH_OP_TRANSFER    8'h0F
`define RMCH_OP_RECOVER     8'h10

// reset values
`define RMCH_IV_RESET       128'h0
`define RMCH_KEY_RESET      128'h0
`define RMCH_RESULT_RESET   8'h00
`define RMCH_LFSR_SEED      16'hACE1

`endif

// ---- hw/rmch_mem.v ----
`timescale 1ns/100ps
module rmch_mem (
  // clock only
  input  wire       clk,
  // write side
  input  wire       wr_en,
  input  wire [3:0] wr_addr,
  input  wire [7:0] wr_data,
  // read side
  input  wire [3:0] rd_addr,
  output reg  [7:0] rd_data_q
);

  reg [7:0] mem_q [0:15];

  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data_q <= mem_q[rd_addr];
  end

endmodule // rmch_mem

// ---- hw/rmch_top.v ----
`timescale 1ns/100ps
`include "rmch_defs.vh"
module rmch_top (
  // clock and reset
  input  wire         clk,
  input  wire         reset_n,
  // serial packet receive
  input  wire         rx_valid,
  input  wire         rx_first,
  input  wire [7:0]   rx_data,
  input  wire         rx_end,
  // serial packet transmit
  input  wire         enc_mode,
  input  wire         tx_ready,
  output reg          tx_valid_q,
  output reg  [7:0]   tx_data_q,
  output reg          tx_last_q,
  output reg          tx_encrypt_q,
  // link cipher settings
  output reg  [127:0] link_iv_q,
  output reg  [127:0] link_key_q,
  // command register
  input  wire         reg_wr,
  input  wire [7:0]   reg_wdata,
  input  wire         comm_busy,
  // tag operation engine
  output reg          op_start_q,
  output reg  [7:0]   op_code_q,
  output reg          op_busy_q,
  input  wire         op_done,
  input  wire [7:0]   op_result,
  // memory update strobes
  output reg  [7:0]   result_q,
  output reg          upd_result_q,
  output reg          upd_tag_q,
  output reg          upd_buffer_q
);

  localparam [1:0] S_IDLE   = 2'b00;
  localparam [1:0] S_ARGS   = 2'b01;
  localparam [1:0] S_COMMIT = 2'b10;
  localparam [1:0] S_TX     = 2'b11;

  localparam [1:0] K_ACK    = 2'b00;
  localparam [1:0] K_NACK   = 2'b01;
  localparam [1:0] K_ASYNC  = 2'b10;

  reg  [1:0]   state_q;
  reg  [7:0]   code_q;
  reg  [4:0]   arg_cnt_q;
  reg  [4:0]   cmt_cnt_q;
  reg  [127:0] shadow_q;
  reg  [1:0]   kind_q;
  reg  [127:0] payload_q;
  reg  [5:0]   tx_len_q;
  reg  [5:0]   tx_idx_q;
  reg          tx_enc_q;
  reg  [15:0]  lfsr_q;
  reg          pend_q;
  reg  [7:0]   pend_code_q;
  reg          async_q;
  reg  [7:0]   async_res_q;

  wire [7:0]   mem_rd_data;
  wire         mem_wr;
  wire [3:0]   mem_rd_addr;

  // byte i of a 128-bit word, least significant byte first
  function [7:0] byte_of;
    input [127:0] word;
    input [5:0]   idx;
    begin
      byte_of = word[idx[3:0]*8 +: 8];
    end
  endfunction

  // total bytes sent, padded to whole cipher blocks when encrypting
  function [5:0] padded_len;
    input [5:0] len;
    input       enc;
    begin
      if (enc)
      begin
        padded_len = (len + 6'h0F) & 6'h30;
      end
      else
      begin
        padded_len = len;
      end
    end
  endfunction

  // operations whose result lands in the data buffer
  function buffer_op;
    input [7:0] code;
    begin
      buffer_op = (code == `RMCH_OP_READ_BLK) || (code == `RMCH_OP_READ_DBLK) ||
                  (code == `RMCH_OP_READ_PAGE) || (code == `RMCH_OP_ENCRYPT) ||
                  (code == `RMCH_OP_DECRYPT) || (code == `RMCH_OP_READ_VAL);
    end
  endfunction

  // staging store for incoming 16-byte arguments
  assign mem_wr      = (state_q == S_ARGS) && rx_valid && !rx_first && (arg_cnt_q < `RMCH_ARG_BYTES);
  assign mem_rd_addr = cmt_cnt_q[3:0];

  rmch_mem u_stage (
    .clk       (clk),
    .wr_en     (mem_wr),
    .wr_addr   (arg_cnt_q[3:0]),
    .wr_data   (rx_data),
    .rd_addr   (mem_rd_addr),
    .rd_data_q (mem_rd_data)
  );

  // byte to send at the current index
  reg [7:0] tx_byte;
  always @*
  begin
    tx_byte = lfsr_q[7:0];
    if (tx_idx_q == 6'h00)
    begin
      case (kind_q)
        K_ACK:   tx_byte = `RMCH_RSP_ACK;
        K_NACK:  tx_byte = `RMCH_RSP_NACK;
        default: tx_byte = `RMCH_RSP_ASYNC;
      endcase
    end
    else if (kind_q == K_ASYNC && tx_idx_q == 6'h01)
    begin
      tx_byte = payload_q[7:0];
    end
    else if (kind_q == K_ACK && tx_idx_q <= 6'h10 && tx_len_q > 6'h01)
    begin
      tx_byte = byte_of(payload_q, tx_idx_q - 6'h01);
    end
  end

  wire tx_adv   = !tx_valid_q || tx_ready;
  wire tx_final = (tx_idx_q == padded_len(tx_len_q, tx_enc_q) - 6'h01);
  // async packet launches when idle and no command code arrives
  wire async_take = (state_q == S_IDLE) && !(rx_valid && rx_first);

  // serial command interpreter and reply sender
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q      <= S_IDLE;
      code_q       <= 8'h00;
      arg_cnt_q    <= 5'h00;
      cmt_cnt_q    <= 5'h00;
      shadow_q     <= 128'h0;
      kind_q       <= K_ACK;
      payload_q    <= 128'h0;
      tx_len_q     <= 6'h00;
      tx_idx_q     <= 6'h00;
      tx_enc_q     <= 1'b0;
      tx_valid_q   <= 1'b0;
      tx_data_q    <= 8'h00;
      tx_last_q    <= 1'b0;
      tx_encrypt_q <= 1'b0;
      link_iv_q    <= `RMCH_IV_RESET;
      link_key_q   <= `RMCH_KEY_RESET;
      lfsr_q       <= `RMCH_LFSR_SEED;
    end
    else
    begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      case (state_q)
        S_IDLE:
        begin
          if (rx_valid && rx_first)
          begin
            code_q    <= rx_data;
            arg_cnt_q <= 5'h00;
            state_q   <= S_ARGS;
          end
          else if (async_q)
          begin
            kind_q       <= K_ASYNC;
            tx_len_q     <= 6'h02;
            tx_idx_q     <= 6'h00;
            tx_enc_q     <= enc_mode;
            payload_q    <= {120'h0, async_res_q};
            state_q      <= S_TX;
          end
        end
        S_ARGS:
        begin
          if (rx_valid && !rx_first && arg_cnt_q != 5'h1F)
          begin
            arg_cnt_q <= arg_cnt_q + 5'h01;
          end
          if (rx_end)
          begin
            tx_idx_q  <= 6'h00;
            tx_enc_q  <= enc_mode;
            cmt_cnt_q <= 5'h00;
            if (code_q == `RMCH_CMD_SET_IV || code_q == `RMCH_CMD_SET_KEY)
            begin
              if (arg_cnt_q == `RMCH_ARG_BYTES)
              begin
                state_q <= S_COMMIT;
              end
              else
              begin
                kind_q   <= K_NACK;
                tx_len_q <= 6'h01;
                state_q  <= S_TX;
              end
            end
            else if (code_q == `RMCH_CMD_READ_IV || code_q == `RMCH_CMD_READ_KEY)
            begin
              if (arg_cnt_q == 5'h00)
              begin
                kind_q    <= K_ACK;
                tx_len_q  <= 6'h11;
                payload_q <= (code_q == `RMCH_CMD_READ_IV) ? link_iv_q : link_key_q;
              end
              else
              begin
                kind_q   <= K_NACK;
                tx_len_q <= 6'h01;
              end
              state_q <= S_TX;
            end
            else
            begin
              state_q <= S_IDLE;
            end
          end
        end
        S_COMMIT:
        begin
          // read data trails the address by one cycle
          if (cmt_cnt_q != 5'h00)
          begin
            shadow_q <= {mem_rd_data, shadow_q[127:8]};
          end
          if (cmt_cnt_q == `RMCH_ARG_BYTES)
          begin
            if (code_q == `RMCH_CMD_SET_IV)
            begin
              link_iv_q <= {mem_rd_data, shadow_q[127:8]};
            end
            else
            begin
              link_key_q <= {mem_rd_data, shadow_q[127:8]};
            end
            // new setting is live before the acknowledge leaves
            kind_q   <= K_ACK;
            tx_len_q <= 6'h01;
            tx_enc_q <= enc_mode;
            state_q  <= S_TX;
          end
          else
          begin
            cmt_cnt_q <= cmt_cnt_q + 5'h01;
          end
        end
        default:
        begin
          if (tx_adv)
          begin
            if (tx_valid_q && tx_last_q)
            begin
              tx_valid_q   <= 1'b0;
              tx_last_q    <= 1'b0;
              state_q      <= S_IDLE;
            end
            else
            begin
              tx_valid_q   <= 1'b1;
              tx_data_q    <= tx_byte;
              tx_last_q    <= tx_final;
              tx_encrypt_q <= tx_enc_q;
              tx_idx_q     <= tx_idx_q + 6'h01;
            end
          end
        end
      endcase
    end
  end

  // tag operation dispatch
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pend_q       <= 1'b0;
      pend_code_q  <= `RMCH_OP_NONE;
      op_start_q   <= 1'b0;
      op_code_q    <= `RMCH_OP_NONE;
      op_busy_q    <= 1'b0;
      result_q     <= `RMCH_RESULT_RESET;
      upd_result_q <= 1'b0;
      upd_tag_q    <= 1'b0;
      upd_buffer_q <= 1'b0;
      async_q      <= 1'b0;
      async_res_q  <= 8'h00;
    end
    else
    begin
      op_start_q   <= 1'b0;
      upd_result_q <= 1'b0;
      upd_tag_q    <= 1'b0;
      upd_buffer_q <= 1'b0;
      if (reg_wr)
      begin
        pend_q      <= 1'b1;
        pend_code_q <= reg_wdata;
      end
      else if (pend_q && !comm_busy && !op_busy_q)
      begin
        pend_q     <= 1'b0;
        op_start_q <= 1'b1;
        op_code_q  <= pend_code_q;
        op_busy_q  <= 1'b1;
      end
      if (op_done && op_busy_q)
      begin
        op_busy_q    <= 1'b0;
        result_q     <= op_result;
        upd_result_q <= 1'b1;
        upd_tag_q    <= (op_code_q == `RMCH_OP_GET_UID);
        upd_buffer_q <= buffer_op(op_code_q);
        async_q      <= 1'b1;
        async_res_q  <= op_result;
      end
      // a completion in the launch cycle wins and queues another packet
      else if (async_take)
      begin
        async_q <= 1'b0;
      end
    end
  end

endmodule // rmch_top

// ---- dv/rmch_properties.sv ----
`timescale 1ns/100ps
module rmch_properties (
  // clock and reset
  input wire         clk,
  input wire         reset_n,
  // tag operation side
  input wire         comm_busy,
  input wire         op_start_q,
  input wire         op_busy_q,
  input wire         op_done,
  input wire [7:0]   op_result,
  input wire [7:0]   op_code_q,
  input wire [7:0]   result_q,
  input wire         upd_result_q,
  input wire         upd_tag_q,
  input wire         upd_buffer_q,
  // serial reply side
  input wire         tx_ready,
  input wire         tx_valid_q,
  input wire [7:0]   tx_data_q,
  input wire         tx_last_q,
  input wire [127:0] link_iv_q,
  input wire [127:0] link_key_q
);
  wire buf_op = op_code_q inside {8'h02, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0A};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_done; op_busy_q && op_done; endsequence
  sequence s_upd; upd_result_q && !op_busy_q && result_q == $past(op_result); endsequence
  a_start_after_comm: assert property (op_start_q |-> !$past(comm_busy) && op_busy_q)
    else $error("start during host transfer");
  a_done_updates: assert property (s_done |=> s_upd)
    else $error("result not updated after done");
  a_upd_has_cause: assert property (upd_result_q |-> $past(op_done) && $past(op_busy_q))
    else $error("result update without done");
  a_tag_upd_code: assert property (upd_tag_q == (upd_result_q && op_code_q == 8'h01))
    else $error("tag update mismatch");
  a_buf_upd_code: assert property (upd_buffer_q == (upd_result_q && buf_op))
    else $error("buffer update mismatch");
  a_code_held: assert property (op_busy_q && !op_start_q |-> $stable(op_code_q))
    else $error("code changed while running");
  a_tx_stands: assert property (tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q) && $stable(tx_last_q))
    else $error("reply byte dropped");
  a_iv_ack: assert property ($changed(link_iv_q) |=> tx_valid_q && tx_data_q == 8'h01)
    else $error("vector change without ack");
  a_key_ack: assert property ($changed(link_key_q) |=> tx_valid_q && tx_data_q == 8'h01)
    else $error("key change without ack");
  a_async_reply: assert property (upd_result_q |-> ##[2:400] (tx_valid_q && tx_data_q == 8'h03))
    else $error("no async response");
endmodule // rmch_properties

// ---- dv/rmch_engine_model.sv ----
`timescale 1ns/100ps
module rmch_engine_model (
  // clock and control
  input  wire       clk,
  input  wire       op_start_q,
  input  wire [4:0] delay,
  input  wire       stray,
  // completion
  output reg        op_done,
  output reg  [7:0] op_result
);
  reg [5:0] cnt_q = 6'h00;
  initial op_done = 1'b0;
  initial op_result = 8'h00;
  always @(posedge clk)
  begin
    // result only meaningful with done, so scramble it otherwise
    op_done <= stray;
    op_result <= ~op_result;
    if (op_start_q)
      cnt_q <= {1'b0, delay} + 6'h01;
    else if (cnt_q != 6'h00)
      cnt_q <= cnt_q - 6'h01;
    if (cnt_q == 6'h01)
    begin
      op_done <= 1'b1;
      op_result <= $urandom;
    end
  end
endmodule // rmch_engine_model

// ---- dv/rmch_top_tb.sv ----
`timescale 1ns/100ps
module rmch_top_tb;
  localparam HOLD = 100;
  reg          clk, reset_n, rx_valid, rx_first, rx_end, enc_mode, tx_ready;
  reg          reg_wr, comm_busy, stray, enc_seen, op_on;
  reg  [7:0]   rx_data, reg_wdata, res_m;
  reg  [4:0]   delay;
  reg  [127:0] iv_m, key_m, arg, w;
  reg  [7:0]   rsp[$];
  wire         tx_valid_q, tx_last_q, tx_encrypt_q, op_start_q, op_busy_q, op_done;
  wire         upd_result_q, upd_tag_q, upd_buffer_q;
  wire [7:0]   tx_data_q, op_code_q, op_result, result_q;
  wire [127:0] link_iv_q, link_key_q;
  integer      err_count, n_tests, nb, nt, i, c, k;
  rmch_top rmch_top_inst (.clk, .reset_n, .rx_valid, .rx_first, .rx_data, .rx_end, .enc_mode, .tx_ready,
    .tx_valid_q, .tx_data_q, .tx_last_q, .tx_encrypt_q, .link_iv_q, .link_key_q, .reg_wr, .reg_wdata,
    .comm_busy, .op_start_q, .op_code_q, .op_busy_q, .op_done, .op_result, .result_q, .upd_result_q,
    .upd_tag_q, .upd_buffer_q);
  rmch_engine_model rmch_engine_model_inst (.clk, .op_start_q, .delay, .stray, .op_done, .op_result);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk_byte(input [7:0] got, input [7:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  end
  endtask
  task chk_word(input [127:0] got, input [127:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  end
  endtask
  task send(input [7:0] code, input integer n, input [127:0] a);
    integer j;
  begin
    @(negedge clk);
    rx_valid = 1'b1;
    rx_first = 1'b1;
    rx_data = code;
    for (j = 0; j < n; j = j + 1)
    begin
      @(negedge clk);
      rx_first = 1'b0;
      rx_data = a[8*(j%16)+:8];
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_end = 1'b1;
    rx_data = ~rx_data;
    @(negedge clk);
    rx_end = 1'b0;
  end
  endtask
  task get;
    integer j;
    reg fin;
  begin
    rsp.delete();
    fin = 1'b0;
    for (j = 0; j < 400 && !fin; j = j + 1)
    begin
      @(negedge clk);
      // byte standing now is taken at the next rising edge
      tx_ready = $urandom;
      if (tx_valid_q === 1'b1 && tx_ready)
      begin
        rsp.push_back(tx_data_q);
        enc_seen = tx_encrypt_q;
        fin = tx_last_q;
      end
    end
    if (!fin)
      chk_byte(8'h00, 8'h01);
  end
  endtask
  task results;
  begin
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // engine result and update strobes seen by the bench
  always @(negedge clk)
  begin
    if (op_done && op_on)
      res_m = op_result;
    if (upd_buffer_q)
      nb = nb + 1;
    if (upd_tag_q)
      nt = nt + 1;
  end
  initial
  begin
    #400000;
    err_count = err_count + 1;
    $display("[ERR] %0t watchdog expired", $time);
    results;
  end
  initial
  begin
    {reset_n, rx_valid, rx_first, rx_end, enc_mode, tx_ready, reg_wr, comm_busy, stray, op_on} = 10'h000;
    {rx_data, reg_wdata, delay, iv_m, key_m} = 0;
    {err_count, n_tests, nb, nt, res_m} = 0;
    void'($urandom(32'h87E25ADC));
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    chk_word(link_iv_q, iv_m);
    chk_word(link_key_q, key_m);
    for (i = 0; i < 4; i = i + 1)
    begin
      enc_mode = i[1];
      c = i[0];
      arg = {$urandom, $urandom, $urandom, $urandom};
      send(8'h11 + c, 16, arg);
      get;
      if (c)
        key_m = arg;
      else
        iv_m = arg;
      w = c ? key_m : iv_m;
      chk_byte(rsp.size(), enc_mode ? 16 : 1);
      chk_byte(rsp[0], 8'h01);
      chk_byte(enc_seen, enc_mode);
      chk_word(c ? link_key_q : link_iv_q, w);
      repeat (HOLD) @(negedge clk);
      send(8'h13 + c, 0, arg);
      get;
      chk_byte(rsp.size(), enc_mode ? 32 : 17);
      chk_byte(rsp[0], 8'h01);
      for (k = 0; k < 16; k = k + 1)
        chk_byte(rsp[k+1], w[8*k+:8]);
      send(8'h13 + c, 1, arg);
      get;
      chk_byte(rsp[0], 8'h02);
      send(8'h11 + c, 15 + 2 * i[1], ~arg);
      get;
      chk_byte(rsp[0], 8'h02);
      chk_word(c ? link_key_q : link_iv_q, w);
    end
    enc_mode = 1'b0;
    @(negedge clk);
    stray = 1'b1;
    @(negedge clk);
    stray = 1'b0;
    repeat (3) @(negedge clk);
    chk_byte(result_q, 8'h00);
    op_on = 1'b1;
    for (c = 1; c < 17; c = c + 1)
    begin
      delay = $urandom;
      nb = 0;
      nt = 0;
      @(negedge clk);
      reg_wr = 1'b1;
      reg_wdata = c;
      comm_busy = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = $urandom;
      repeat ($urandom % 4) @(negedge clk);
      comm_busy = 1'b0;
      get;
      chk_byte(rsp.size(), 2);
      chk_byte(rsp[0], 8'h03);
      chk_byte(rsp[1], res_m);
      chk_byte(result_q, res_m);
      chk_byte(op_code_q, c);
      chk_byte(nt, c == 1);
      chk_byte(nb, c == 2 || c == 4 || c == 6 || c == 8 || c == 9 || c == 10);
    end
    results;
  end
endmodule // rmch_top_tb
bind rmch_top rmch_properties rmch_properties_inst (.clk, .reset_n, .comm_busy, .op_start_q, .op_busy_q,
  .op_done, .op_result, .op_code_q, .result_q, .upd_result_q, .upd_tag_q, .upd_buffer_q, .tx_ready,
  .tx_valid_q, .tx_data_q, .tx_last_q, .link_iv_q, .link_key_q);
